// >>> src/sadc_regs.svh
// register map, field positions and timing counts of the converter control
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// register indices; byte address is four times the index
`define SADC_IDX_CTRL_ONE 6'h0e
`define SADC_IDX_CTRL_TWO 6'h0f
`define SADC_IDX_RES_LOW 6'h20
`define SADC_IDX_RES_HIGH 6'h21

`define SADC_CTRL_ONE_RST 8'h10
`define SADC_CTRL_TWO_RST 6'h10

// control one fields
`define SADC_START_BIT 7
`define SADC_MODE_HI 6
`define SADC_MODE_LO 5
`define SADC_AIN_DIS_BIT 4
`define SADC_CHAN_HI 3
`define SADC_CHAN_LO 0
// control two fields
`define SADC_LADDER_BIT 5
`define SADC_TIME_HI 3
`define SADC_TIME_LO 1

// operating mode codes
`define SADC_MODE_OFF 2'h0
`define SADC_MODE_SINGLE 2'h1
`define SADC_MODE_REPEAT 2'h3

// conversion time codes
`define SADC_TIME_39 3'h0
`define SADC_TIME_78 3'h2
`define SADC_TIME_156 3'h3
`define SADC_TIME_312 3'h4
`define SADC_TIME_624 3'h5
`define SADC_TIME_1248 3'h6

// a conversion spans 13 equal phases: 2 sample, 10 bit trials, 1 settle
`define SADC_PHASES 4'hd
`define SADC_PH_LAST 4'hc
`define SADC_PH_FIRST_BIT 4'h2
`define SADC_PH_LAST_BIT 4'hb
// cycles per phase for each time code (39/13 up to 1248/13)
`define SADC_PER_39 7'h03
`define SADC_PER_78 7'h06
`define SADC_PER_156 7'h0c
`define SADC_PER_312 7'h18
`define SADC_PER_624 7'h30
`define SADC_PER_1248 7'h60

`define SADC_RES_MID 10'h200

`endif

// >>> src/sadc_pkg.sv
// types shared by the converter control modules
package sadc_pkg;
    typedef enum logic [1:0] {
        SADC_IDLE = 2'b01,
        SADC_RUN = 2'b10
    } sadc_state_e;
    typedef logic [6:0] sadc_per_t;
endpackage

// >>> src/sadc_sar_if.sv
// signals between the register front end and the successive-approximation core
`timescale 1ns/1ps
`default_nettype none
interface sadc_sar_if #(parameter int RES_W = 10);
    logic start;
    logic abort;
    logic [6:0] period;
    logic busy;
    logic done;
    logic [RES_W-1:0] result;
    modport ctl (output start, output abort, output period,
                 input busy, input done, input result);
    modport sar (input start, input abort, input period,
                 output busy, output done, output result);
endinterface
`default_nettype wire

// >>> src/sadc_sar.sv
// successive-approximation sequencer with comparator synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.svh"
module sadc_sar
    import sadc_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic sys_clk,
    input wire logic nrst,
    sadc_sar_if.sar sar,
    input wire logic comp_in,
    output logic sample_hold,
    output logic [RES_W-1:0] dac_code
);
    generate
        if (RES_W != 10) begin : g_bad_width
            $error("sadc_sar: phase plan serves ten result bits only");
        end
    endgenerate

    sadc_state_e state, next_state;
    sadc_per_t per, next_per;
    logic [6:0] pc, next_pc;
    logic [3:0] ph, next_ph;
    logic [RES_W-1:0] trial, next_trial;
    logic conv_end;
    logic [2:0] sync, next_sync;
    logic comp_q, next_comp_q;
    logic [3:0] bit_no;

    // comparator is asynchronous: accept a change once stages two and three agree
    always_comb begin
        next_sync = {sync[1:0], comp_in};
        next_comp_q = (sync[1] == sync[2]) ? sync[2] : comp_q;
    end

    assign bit_no = 4'(`SADC_PH_LAST_BIT - ph);

    always_comb begin
        next_state = state;
        next_per = per;
        next_pc = pc;
        next_ph = ph;
        next_trial = trial;
        conv_end = 1'b0;
        case (state)
            SADC_IDLE: begin
                if (sar.start) begin
                    next_state = SADC_RUN;
                    next_per = sar.period;
                    next_pc = 7'h00;
                    next_ph = 4'h0;
                    next_trial = `SADC_RES_MID;
                end
            end
            SADC_RUN: begin
                if (sar.abort) begin
                    next_state = SADC_IDLE;
                end else if (pc == 7'(per - 7'h01)) begin
                    next_pc = 7'h00;
                    if (ph >= `SADC_PH_FIRST_BIT && ph <= `SADC_PH_LAST_BIT)
                    begin
                        if (!comp_q) begin
                            next_trial[bit_no] = 1'b0;
                        end
                        if (bit_no != 4'h0) begin
                            next_trial[bit_no - 4'h1] = 1'b1;
                        end
                    end
                    if (ph == `SADC_PH_LAST) begin
                        next_state = SADC_IDLE;
                        // front end stores trial on the edge that ends busy
                        conv_end = 1'b1;
                    end else begin
                        next_ph = 4'(ph + 4'h1);
                    end
                end else begin
                    next_pc = 7'(pc + 7'h01);
                end
            end
            default: next_state = SADC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= SADC_IDLE;
            per <= `SADC_PER_39;
            pc <= 7'h00;
            ph <= 4'h0;
            trial <= '0;
            sync <= 3'h0;
            comp_q <= 1'b0;
        end else begin
            state <= next_state;
            per <= next_per;
            pc <= next_pc;
            ph <= next_ph;
            trial <= next_trial;
            sync <= next_sync;
            comp_q <= next_comp_q;
        end
    end

    assign sar.busy = (state == SADC_RUN);
    assign sar.done = conv_end;
    assign sar.result = trial;
    assign sample_hold = (state == SADC_RUN) && (ph < `SADC_PH_FIRST_BIT);
    assign dac_code = trial;
endmodule
`default_nettype wire

// >>> src/sadc_top.sv
// converter control: register front end on Avalon-MM and conversion sequencing
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.svh"
module sadc_top
    import sadc_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic standby,
    input wire logic comp_in,
    output logic [3:0] channel_select_field,
    output logic analog_input_disable_bit,
    output logic ladder_connect,
    output logic sample_hold,
    output logic [RES_W-1:0] dac_code,
    output logic conversion_done_interrupt,
    output logic converter_busy_flag
);
    generate
        if (RES_W != 10) begin : g_bad_width
            $error("sadc_top: register layout serves ten result bits only");
        end
    endgenerate

    function automatic logic hit(input logic [7:0] addr,
                                 input logic [5:0] idx);
        hit = (addr[1:0] == 2'b00) && (addr[7:2] == idx);
    endfunction

    function automatic sadc_per_t period_of(input logic [2:0] code);
        case (code)
            `SADC_TIME_78: period_of = `SADC_PER_78;
            `SADC_TIME_156: period_of = `SADC_PER_156;
            `SADC_TIME_312: period_of = `SADC_PER_312;
            `SADC_TIME_624: period_of = `SADC_PER_624;
            `SADC_TIME_1248: period_of = `SADC_PER_1248;
            // reserved codes run at the shortest time
            default: period_of = `SADC_PER_39;
        endcase
    endfunction

    sadc_sar_if #(.RES_W(RES_W)) link ();

    sadc_sar #(.RES_W(RES_W)) u_sar (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sar(link),
        .comp_in(comp_in),
        .sample_hold(sample_hold),
        .dac_code(dac_code)
    );

    // bus front end
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic req, acc, wr_acc, rd_acc;

    assign req = avs_read | avs_write;
    assign acc = req & ack;
    assign wr_acc = acc & avs_write;
    assign rd_acc = acc & avs_read;
    assign avs_waitrequest = req & ~ack;

    // control and status state
    logic [7:0] ctrl_one, next_ctrl_one;
    logic [5:0] ctrl_two, next_ctrl_two;
    logic eoc, next_eoc;
    logic [RES_W-1:0] result, next_result;
    logic irq, next_irq;
    logic [1:0] mode;
    logic launch, repeat_go, abort_now;

    assign mode = ctrl_one[`SADC_MODE_HI:`SADC_MODE_LO];

    // a pending start launches only from idle in an enabled mode
    assign launch = ctrl_one[`SADC_START_BIT] && !link.busy && !standby &&
                    (mode == `SADC_MODE_SINGLE ||
                     mode == `SADC_MODE_REPEAT);
    // relaunch while the done pulse stands, one idle cycle after completion
    assign repeat_go = irq && mode == `SADC_MODE_REPEAT &&
                       !standby;
    assign abort_now = standby || mode == `SADC_MODE_OFF;

    assign link.start = launch | repeat_go;
    assign link.abort = abort_now;
    assign link.period =
        period_of(ctrl_two[`SADC_TIME_HI:`SADC_TIME_LO]);

    always_comb begin
        next_ack = req & ~ack;
        next_rdata = rdata;
        if (req && !ack) begin
            next_rdata = 32'h0;
            if (hit(avs_address, `SADC_IDX_CTRL_ONE)) begin
                next_rdata[7:0] = ctrl_one;
            end else if (hit(avs_address, `SADC_IDX_CTRL_TWO)) begin
                next_rdata[7:0] = {2'b00, ctrl_two};
            end else if (hit(avs_address, `SADC_IDX_RES_HIGH)) begin
                next_rdata[7:0] = result[9:2];
            end else if (hit(avs_address, `SADC_IDX_RES_LOW)) begin
                next_rdata[7:0] = {result[1:0], eoc, link.busy, 4'h0};
            end
        end
    end

    always_comb begin
        next_ctrl_one = ctrl_one;
        next_ctrl_two = ctrl_two;
        next_eoc = eoc;
        next_result = result;
        next_irq = 1'b0;
        // start bit is one-shot: cleared on the cycle after it is seen
        next_ctrl_one[`SADC_START_BIT] = 1'b0;
        if (wr_acc && hit(avs_address, `SADC_IDX_CTRL_ONE)) begin
            next_ctrl_one = avs_writedata[7:0];
        end
        if (wr_acc && hit(avs_address, `SADC_IDX_CTRL_TWO)) begin
            next_ctrl_two = avs_writedata[5:0];
        end
        // high result read clears end flag, as does a fresh launch
        if (rd_acc && hit(avs_address, `SADC_IDX_RES_HIGH)) begin
            next_eoc = 1'b0;
        end
        if (link.start) begin
            next_eoc = 1'b0;
        end
        if (link.done) begin
            // set wins over a clear in the same cycle
            next_result = link.result;
            next_eoc = 1'b1;
            next_irq = 1'b1;
        end
        if (standby) begin
            next_ctrl_one = `SADC_CTRL_ONE_RST;
            next_ctrl_two = `SADC_CTRL_TWO_RST;
            next_result = '0;
            next_eoc = 1'b0;
            next_irq = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack <= 1'b0;
            rdata <= 32'h0;
            ctrl_one <= `SADC_CTRL_ONE_RST;
            ctrl_two <= `SADC_CTRL_TWO_RST;
            eoc <= 1'b0;
            result <= '0;
            irq <= 1'b0;
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
            ctrl_one <= next_ctrl_one;
            ctrl_two <= next_ctrl_two;
            eoc <= next_eoc;
            result <= next_result;
            irq <= next_irq;
        end
    end

    assign avs_readdata = rdata;
    assign channel_select_field = ctrl_one[`SADC_CHAN_HI:`SADC_CHAN_LO];
    assign analog_input_disable_bit = ctrl_one[`SADC_AIN_DIS_BIT];
    // ladder drops in standby since its bit is forced to reset there
    assign ladder_connect = ctrl_two[`SADC_LADDER_BIT] | link.busy;
    assign conversion_done_interrupt = irq;
    assign converter_busy_flag = link.busy;
endmodule
`default_nettype wire

// >>> sim/sadc_top_properties.sv
// port-level assertions for the converter control top
`timescale 1ns/1ps
`default_nettype none
module sadc_top_checker #(
    parameter int RES_W = 10
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic standby,
    input wire logic comp_in,
    input wire logic [3:0] channel_select_field,
    input wire logic analog_input_disable_bit,
    input wire logic ladder_connect,
    input wire logic sample_hold,
    input wire logic [RES_W-1:0] dac_code,
    input wire logic conversion_done_interrupt,
    input wire logic converter_busy_flag
);
    logic [10:0] busy_len;
    logic [10:0] next_busy_len;
    logic wr_ctl;
    // cycles the busy flag has been high in a row
    always_comb begin
        next_busy_len = converter_busy_flag ? busy_len + 11'h1 : 11'h0;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_len <= 11'h0;
        end else begin
            busy_len <= next_busy_len;
        end
    end
    assign wr_ctl = avs_write && !avs_waitrequest && avs_address == 8'h38;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    AST_START_RUN: assert property (wr_ctl && avs_writedata[7]
        && avs_writedata[5] && !converter_busy_flag && !standby
        |-> ##2 converter_busy_flag) else $error("start did not launch");
    AST_MODE_NO_RUN: assert property (wr_ctl && avs_writedata[7]
        && !avs_writedata[5] && !converter_busy_flag
        |-> ##2 !converter_busy_flag) else $error("start ran while off");
    AST_CTRL_PINS: assert property (wr_ctl && !standby |=>
        analog_input_disable_bit == $past(avs_writedata[4])
        && channel_select_field == $past(avs_writedata[3:0]))
        else $error("control pins do not follow write");
    AST_ABORT: assert property (wr_ctl && avs_writedata[6:5] == 2'h0
        |-> ##2 !converter_busy_flag) else $error("abort did not stop");
    AST_DONE_PULSE: assert property (conversion_done_interrupt
        |=> !conversion_done_interrupt) else $error("done pulse too long");
    AST_DONE_ENDS_BUSY: assert property (conversion_done_interrupt |->
        !converter_busy_flag && $past(converter_busy_flag))
        else $error("done without busy falling");
    AST_TIME: assert property (conversion_done_interrupt |-> busy_len
        inside {11'h027, 11'h04e, 11'h09c, 11'h138, 11'h270, 11'h4e0})
        else $error("conversion length wrong");
    AST_LADDER: assert property (converter_busy_flag
        |-> ladder_connect) else $error("ladder open while busy");
    AST_STANDBY: assert property (standby |=> !converter_busy_flag
        && analog_input_disable_bit && channel_select_field == 4'h0)
        else $error("standby did not reset control");
endmodule
bind sadc_top sadc_top_checker #(.RES_W(RES_W)) i_chk (.sys_clk, .nrst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .standby, .comp_in, .channel_select_field,
    .analog_input_disable_bit, .ladder_connect, .sample_hold, .dac_code,
    .conversion_done_interrupt, .converter_busy_flag);
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic standby = 1'b0;
    logic comp_in = 1'b0;
    logic [3:0] channel_select_field;
    logic analog_input_disable_bit, ladder_connect, sample_hold;
    logic [9:0] dac_code;
    logic conversion_done_interrupt, converter_busy_flag;
    logic [7:0] rd;
    int errors = 0;
    int cmp_count = 0;
    int busy_cnt = 0;
    int irq_cnt = 0;
    int sh_cnt = 0;
    int snap;
    int cyc[6] = '{39, 78, 156, 312, 624, 1248};
    logic [2:0] tc[6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    always #12.5 sys_clk = ~sys_clk;
    // counted on the falling edge so the posedge waits never race them
    always @(negedge sys_clk) begin
        if (converter_busy_flag === 1'b1) busy_cnt++;
        if (conversion_done_interrupt === 1'b1) irq_cnt++;
        if (sample_hold === 1'b1) sh_cnt++;
    end
    sadc_top i_dut (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .standby, .comp_in,
        .channel_select_field, .analog_input_disable_bit, .ladder_connect,
        .sample_hold, .dac_code, .conversion_done_interrupt,
        .converter_busy_flag);
    task automatic print_verdict;
        $display("compares %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one Avalon access; holds the request until waitrequest is seen low
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                errors++;
                print_verdict();
            end
            @(posedge sys_clk);
        end
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk({24'h0, rd & m}, {24'h0, e});
    endtask
    task automatic wait_irq(input int k);
        int n;
        n = 0;
        while (irq_cnt < k) begin
            n++;
            if (n > 3000) begin
                errors++;
                print_verdict();
            end
            @(posedge sys_clk);
        end
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rchk(8'h38, 8'hff, 8'h10);
        rchk(8'h3c, 8'h3f, 8'h10);
        rchk(8'h80, 8'hff, 8'h00);
        rchk(8'h40, 8'hff, 8'h00);
        chk(analog_input_disable_bit, 1'b1);
        $display("test reset values done");
        for (int k = 0; k < 6; k++) begin
            comp_in <= k[0];
            acc(1'b1, 8'h3c, {4'h1, tc[k], 1'b0});
            busy_cnt = 0;
            irq_cnt = 0;
            sh_cnt = 0;
            acc(1'b1, 8'h38, {4'ha, k[3:0]});
            chk(channel_select_field, k[3:0]);
            chk(analog_input_disable_bit, 1'b0);
            wait_irq(1);
            chk(busy_cnt, cyc[k]);
            chk(sh_cnt, cyc[k] * 2 / 13);
            chk(dac_code, k[0] ? 10'h3ff : 10'h000);
            rchk(8'h38, 8'hff, {4'h2, k[3:0]});
            rchk(8'h80, 8'hf0, k[0] ? 8'he0 : 8'h20);
            rchk(8'h84, 8'hff, k[0] ? 8'hff : 8'h00);
            rchk(8'h80, 8'h30, 8'h00);
            chk(irq_cnt, 1);
        end
        $display("test conversion times done");
        busy_cnt = 0;
        acc(1'b1, 8'h38, 8'h93);
        acc(1'b1, 8'h38, 8'hc3);
        repeat (4) @(posedge sys_clk);
        chk(busy_cnt, 0);
        rchk(8'h38, 8'hff, 8'h43);
        $display("test refused starts done");
        acc(1'b1, 8'h3c, 8'h10);
        busy_cnt = 0;
        irq_cnt = 0;
        acc(1'b1, 8'h38, 8'he3);
        wait_irq(2);
        chk(busy_cnt, 78);
        acc(1'b1, 8'h38, 8'h03);
        @(posedge sys_clk);
        chk(converter_busy_flag, 1'b0);
        snap = irq_cnt;
        repeat (100) @(posedge sys_clk);
        chk(irq_cnt, snap);
        rchk(8'h80, 8'h30, 8'h00);
        $display("test repeat and abort done");
        acc(1'b1, 8'h3c, 8'h3c);
        chk(ladder_connect, 1'b1);
        acc(1'b1, 8'h38, 8'ha3);
        repeat (3) @(posedge sys_clk);
        standby <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(converter_busy_flag, 1'b0);
        acc(1'b1, 8'h38, 8'h25);
        rchk(8'h38, 8'hff, 8'h10);
        rchk(8'h3c, 8'h3f, 8'h10);
        chk(ladder_connect, 1'b0);
        standby <= 1'b0;
        @(posedge sys_clk);
        acc(1'b1, 8'h38, 8'h25);
        rchk(8'h38, 8'hff, 8'h25);
        $display("test standby done");
        print_verdict();
    end
endmodule
`default_nettype wire
